// [core/fcs_pkg.sv]
// fetch cycle sequencer package: timing steps, layouts, control carriers
// assumes one clock; each clock time is two steps, delay D1 then D2
package fcs_pkg;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int WORD_W = 36;
  localparam int TAG_LO = 18;
  localparam int TAG_HI = 20;
  localparam int ADR_LO = 21;
  localparam int IND_A = 12;
  localparam int IND_B = 13;

  // ---------------------------------------------------------------
  // step numbers: step = clock time * 2 + (delay - 1)
  // ---------------------------------------------------------------
  localparam logic [3:0] STEP_LAST = 4'hd;
  localparam logic [3:0] STEP_SEND = 4'hd;
  localparam logic [3:0] STEP_I1D1 = 4'h2;
  localparam logic [3:0] STEP_I4D1 = 4'h8;
  localparam logic [3:0] STEP_I4D2 = 4'h9;
  localparam logic [3:0] STEP_I5D1 = 4'ha;
  localparam logic [3:0] STEP_E4D1 = 4'h8;

  // ---------------------------------------------------------------
  // adder operands and fixed values
  // ---------------------------------------------------------------
  localparam logic [14:0] INC_OPND = 15'h0001;
  localparam logic [14:0] DEC_OPND = 15'h7fff;
  localparam logic [14:0] ZERO_ADDR = 15'h0000;
  localparam logic [5:0] POD_SHIFT = 6'h3e;
  localparam logic [9:0] TRAP_OPCODE = 10'h001;
  localparam logic [9:0] OPCODE_RST = 10'h000;

  typedef enum logic [1:0] {SRC_PTR, SRC_HOLD, SRC_BUF} fcs_src_t;
  typedef enum logic [1:0] {CYC_FETCH, CYC_EXEC, CYC_LOGIC} fcs_cyc_t;

  // address send and pointer update controls
  typedef struct packed {
    fcs_src_t src;
    logic decrement;
    logic upd_to_buf;
    logic upd_block;
    logic force_one;
    logic overlap;
    logic diag;
  } fcs_addr_ctl_t;

  // instruction decode facts for steering and next cycle choice
  typedef struct packed {
    logic ext_trap;
    logic special;
    logic special_even;
    logic prefix_form;
    logic index_test_instr;
    logic tix_pass;
    logic overlap_ok;
    logic indexable;
    logic index_sel;
    logic indirect_ok;
    logic one_cycle;
    logic exec_test;
  } fcs_instr_ctl_t;

endpackage : fcs_pkg

// [core/fcs_fetch_cycle_sequencer.sv]
// fetch cycle sequencer: address send, pointer update, bus steering,
// index modification and next cycle choice
// assumes core storage answers on both buses by clock time 4
module fcs_fetch_cycle_sequencer (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire fcs_pkg::fcs_addr_ctl_t i_addr_ctl,
  input wire fcs_pkg::fcs_instr_ctl_t i_instr_ctl,
  input wire logic [0:35] i_even_bus,
  input wire logic [0:35] i_odd_bus,
  input wire logic [3:17] i_index_reg,
  input wire logic i_fetch_req,
  input wire logic i_chan_req,
  output logic [3:17] o_even_addr,
  output logic [3:17] o_odd_addr,
  output logic o_even_sel,
  output logic o_odd_sel,
  output logic [3:17] o_instr_pointer,
  output logic [3:17] o_addr_hold,
  output logic [0:35] o_buffer,
  output logic [0:35] o_storage_word,
  output logic [18:20] o_tag_bits,
  output logic [0:9] o_opcode,
  output logic [3:17] o_shift_count,
  output logic o_buffer_loaded,
  output logic o_cond_met,
  output logic o_pre_indirect,
  output logic o_end_op,
  output logic o_fetch_active,
  output logic o_exec_active,
  output logic o_logic_active
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // fifteen bit index adder, carry out dropped as in the hardware
  function automatic logic [3:17] add15(input logic [3:17] a,
                                        input logic [3:17] b,
                                        input logic cin);
    logic [15:0] s;
    s = {1'b0, a} + {1'b0, b} + {15'h0000, cin};
    return s[14:0];
  endfunction : add15

  logic [3:17] instr_pointer_reg;
  logic [3:17] addr_hold_reg;
  logic [0:35] lookahead_instr_buffer_reg;

  // register chosen as an address source
  function automatic logic [3:17] src_val(input fcs_pkg::fcs_src_t s,
                                          input logic [3:17] p,
                                          input logic [3:17] h,
                                          input logic [3:17] b);
    unique case (s)
      fcs_pkg::SRC_PTR: return p;
      fcs_pkg::SRC_HOLD: return h;
      default: return b;
    endcase
  endfunction : src_val

  // ---------------------------------------------------------------
  // cycle timing
  // ---------------------------------------------------------------
  logic [3:0] step_reg;
  fcs_pkg::fcs_cyc_t cyc_reg;
  fcs_pkg::fcs_cyc_t next_cyc_reg;
  fcs_pkg::fcs_cyc_t next_cyc;
  logic stall;
  logic in_fetch;

  assign in_fetch = (cyc_reg == fcs_pkg::CYC_FETCH);
  // only logic cycles may share storage with channel cycles
  assign stall = i_chan_req && (step_reg == 4'h0) && !(cyc_reg == fcs_pkg::CYC_LOGIC);

  // step counter, held at time 0 while channel cycles are owed
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      step_reg <= 4'h0;
    end else if (!stall) begin
      step_reg <= (step_reg == fcs_pkg::STEP_LAST) ? 4'h0 : step_reg + 4'h1;
    end
  end

  // next cycle choice
  always_comb begin
    if (in_fetch) begin
      if ((o_storage_word[fcs_pkg::IND_A] || o_storage_word[fcs_pkg::IND_B]) &&
          i_instr_ctl.indexable && i_instr_ctl.indirect_ok) begin
        next_cyc = fcs_pkg::CYC_EXEC;
      end else if (i_instr_ctl.one_cycle) begin
        next_cyc = fcs_pkg::CYC_FETCH;
      end else if (i_instr_ctl.exec_test) begin
        next_cyc = fcs_pkg::CYC_EXEC;
      end else begin
        next_cyc = fcs_pkg::CYC_LOGIC;
      end
    end else begin
      next_cyc = i_fetch_req ? fcs_pkg::CYC_FETCH : fcs_pkg::CYC_LOGIC;
    end
  end

  logic decide;
  assign decide = (step_reg == fcs_pkg::STEP_I5D1);

  // cycle type, taken over at the cycle boundary
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cyc_reg <= fcs_pkg::CYC_LOGIC;
      next_cyc_reg <= fcs_pkg::CYC_LOGIC;
    end else begin
      if (decide) next_cyc_reg <= next_cyc;
      if (step_reg == fcs_pkg::STEP_LAST) cyc_reg <= next_cyc_reg;
    end
  end

  // ---------------------------------------------------------------
  // master triggers
  // ---------------------------------------------------------------
  logic fetch_trig_reg;
  logic exec_trig_reg;
  logic logic_trig_reg;
  logic pre_indirect_reg;
  logic end_op_reg;

  // fetch trigger on from I5 of the previous cycle to I5 of its own
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) fetch_trig_reg <= 1'b0;
    else if (decide) fetch_trig_reg <= (next_cyc == fcs_pkg::CYC_FETCH);
  end

  // execute trigger early for own addressing, reset at E4
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      exec_trig_reg <= 1'b0;
    end else if (decide && next_cyc == fcs_pkg::CYC_EXEC) begin
      exec_trig_reg <= 1'b1;
    end else if (cyc_reg == fcs_pkg::CYC_EXEC && step_reg == fcs_pkg::STEP_E4D1) begin
      exec_trig_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) logic_trig_reg <= 1'b0;
    else if (decide) logic_trig_reg <= (next_cyc == fcs_pkg::CYC_LOGIC);
  end

  // pre-indirect and end-op reflect the latest fetch decision
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pre_indirect_reg <= 1'b0;
      end_op_reg <= 1'b0;
    end else if (decide) begin
      pre_indirect_reg <= in_fetch && next_cyc == fcs_pkg::CYC_EXEC &&
                          (o_storage_word[fcs_pkg::IND_A] || o_storage_word[fcs_pkg::IND_B]);
      end_op_reg <= in_fetch && next_cyc == fcs_pkg::CYC_FETCH;
    end
  end

  // trigger outputs, fetch and execute gated by channel requests; the delayed execute gating lasts the cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_fetch_active <= 1'b0;
      o_exec_active <= 1'b0;
      o_logic_active <= 1'b0;
    end else begin
      o_fetch_active <= fetch_trig_reg && !i_chan_req;
      o_exec_active <= (exec_trig_reg || cyc_reg == fcs_pkg::CYC_EXEC) && !i_chan_req;
      o_logic_active <= logic_trig_reg;
    end
  end

  // ---------------------------------------------------------------
  // address send at time 6 D2 ahead of the fetch cycle
  // ---------------------------------------------------------------
  logic send;
  logic [3:17] first_addr;
  logic [3:17] second_addr;
  logic second_ok;
  fcs_pkg::fcs_src_t upd_origin_reg;
  logic upd_dec_reg;
  logic upd_to_buf_reg;
  logic upd_block_reg;
  logic force_one_reg;

  assign send = fetch_trig_reg && (step_reg == fcs_pkg::STEP_SEND);
  assign first_addr = src_val(i_addr_ctl.src, instr_pointer_reg, addr_hold_reg,
                              lookahead_instr_buffer_reg[fcs_pkg::ADR_LO:35]);
  // second path always computed; gated onto a latch only in overlap
  assign second_addr = add15(first_addr, i_addr_ctl.decrement ? fcs_pkg::DEC_OPND :
                             fcs_pkg::INC_OPND, 1'b0);
  assign second_ok = i_addr_ctl.overlap && !i_addr_ctl.diag;

  // latches pick by parity of each address
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_even_addr <= fcs_pkg::ZERO_ADDR;
      o_odd_addr <= fcs_pkg::ZERO_ADDR;
      o_even_sel <= 1'b0;
      o_odd_sel <= 1'b0;
    end else if (send) begin
      o_even_sel <= !first_addr[17] || second_ok;
      o_odd_sel <= first_addr[17] || second_ok;
      o_even_addr <= first_addr[17] ? second_addr : first_addr;
      o_odd_addr <= first_addr[17] ? first_addr : second_addr;
    end else begin
      o_even_sel <= 1'b0;
      o_odd_sel <= 1'b0;
    end
  end

  // remember how the update address was stored
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      upd_origin_reg <= fcs_pkg::SRC_PTR;
      upd_dec_reg <= 1'b0;
      upd_to_buf_reg <= 1'b0;
      upd_block_reg <= 1'b1;
      force_one_reg <= 1'b0;
    end else if (send) begin
      upd_origin_reg <= i_addr_ctl.src;
      upd_dec_reg <= i_addr_ctl.decrement;
      upd_to_buf_reg <= i_addr_ctl.upd_to_buf;
      upd_block_reg <= i_addr_ctl.upd_block;
      force_one_reg <= i_addr_ctl.force_one;
    end
  end

  // ---------------------------------------------------------------
  // instruction pointer update at I1(D1)
  // ---------------------------------------------------------------
  fcs_pkg::fcs_src_t upd_src;
  // a decremented copy is wrong by two, so the originator holds it
  assign upd_src = upd_dec_reg ? upd_origin_reg :
                   (upd_to_buf_reg ? fcs_pkg::SRC_BUF : fcs_pkg::SRC_HOLD);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      instr_pointer_reg <= fcs_pkg::ZERO_ADDR;
    end else if (in_fetch && step_reg == fcs_pkg::STEP_I1D1) begin
      if (force_one_reg) begin
        instr_pointer_reg <= add15(fcs_pkg::ZERO_ADDR, fcs_pkg::ZERO_ADDR, 1'b1);
      end else if (!upd_block_reg) begin
        instr_pointer_reg <= add15(src_val(upd_src, instr_pointer_reg, addr_hold_reg,
                                   lookahead_instr_buffer_reg[fcs_pkg::ADR_LO:35]),
                                   fcs_pkg::ZERO_ADDR, 1'b0);
      end
    end
  end

  // ---------------------------------------------------------------
  // storage bus steering from I4
  // ---------------------------------------------------------------
  logic even_to_op;
  logic [0:35] op_word;
  logic [0:35] buf_word;
  logic [3:17] mod_addr;
  logic at_i4d1;
  logic at_i4d2;
  logic at_i5d1;

  assign at_i4d1 = in_fetch && step_reg == fcs_pkg::STEP_I4D1;
  assign at_i4d2 = in_fetch && step_reg == fcs_pkg::STEP_I4D2;
  assign at_i5d1 = in_fetch && step_reg == fcs_pkg::STEP_I5D1;
  assign even_to_op = i_instr_ctl.special ? i_instr_ctl.special_even :
                      instr_pointer_reg[17];
  assign op_word = even_to_op ? i_even_bus : i_odd_bus;
  assign buf_word = even_to_op ? i_odd_bus : i_even_bus;

  // storage word and tag bits; kept as they were on a trap
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_storage_word <= 36'h000000000;
      o_tag_bits <= 3'h0;
    end else if (at_i4d1 && !i_instr_ctl.ext_trap) begin
      o_storage_word <= op_word;
      o_tag_bits <= op_word[fcs_pkg::TAG_LO:fcs_pkg::TAG_HI];
    end
  end

  // opcode, short form fills only sign and bits 8-9
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_opcode <= fcs_pkg::OPCODE_RST;
    end else if (at_i4d1) begin
      if (i_instr_ctl.ext_trap) o_opcode <= fcs_pkg::TRAP_OPCODE;
      else if (i_instr_ctl.prefix_form) o_opcode <= {op_word[0], 7'h00, op_word[1:2]};
      else o_opcode <= {op_word[0], op_word[3:11]};
    end
  end

  // buffer: word at D1, index test copy wins at D2, address at send
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lookahead_instr_buffer_reg <= 36'h000000000;
    end else if (send && i_addr_ctl.upd_to_buf) begin
      lookahead_instr_buffer_reg[fcs_pkg::ADR_LO:35] <= second_addr;
    end else if (at_i4d1 && !i_instr_ctl.ext_trap) begin
      lookahead_instr_buffer_reg <= buf_word;
    end else if (at_i4d2 && !i_instr_ctl.ext_trap && i_instr_ctl.index_test_instr) begin
      lookahead_instr_buffer_reg <= op_word;
    end
  end

  // buffer-loaded and condition-met, decided once the opcode is in
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_buffer_loaded <= 1'b0;
      o_cond_met <= 1'b0;
    end else if (at_i4d1) begin
      o_cond_met <= 1'b0;
    end else if (at_i4d2) begin
      o_buffer_loaded <= i_instr_ctl.overlap_ok && !i_instr_ctl.ext_trap;
      o_cond_met <= i_instr_ctl.index_test_instr && i_instr_ctl.tix_pass;
    end
  end

  // ---------------------------------------------------------------
  // index modification at I5(D1)
  // ---------------------------------------------------------------
  // no index selected gates all ones, i.e. subtracts zero
  assign mod_addr = add15(o_storage_word[fcs_pkg::ADR_LO:35],
                          ~(i_instr_ctl.index_sel ? i_index_reg : fcs_pkg::ZERO_ADDR),
                          1'b1);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      addr_hold_reg <= fcs_pkg::ZERO_ADDR;
    end else if (send && !i_addr_ctl.upd_to_buf) begin
      addr_hold_reg <= second_addr;
    end else if (at_i5d1 && !i_instr_ctl.index_test_instr && i_instr_ctl.indexable) begin
      addr_hold_reg <= mod_addr;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_shift_count <= fcs_pkg::ZERO_ADDR;
    end else if (at_i5d1 && !i_instr_ctl.index_test_instr && i_instr_ctl.indexable &&
                 o_opcode[0:5] == fcs_pkg::POD_SHIFT) begin
      o_shift_count <= mod_addr;
    end
  end

  // register mirrors
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_instr_pointer <= fcs_pkg::ZERO_ADDR;
      o_addr_hold <= fcs_pkg::ZERO_ADDR;
      o_buffer <= 36'h000000000;
      o_pre_indirect <= 1'b0;
      o_end_op <= 1'b0;
    end else begin
      o_instr_pointer <= instr_pointer_reg;
      o_addr_hold <= addr_hold_reg;
      o_buffer <= lookahead_instr_buffer_reg;
      o_pre_indirect <= pre_indirect_reg;
      o_end_op <= end_op_reg;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  chk_second_latch: assert property (send && !second_ok |=> !(o_even_sel && o_odd_sel))
    else $error("second address latched outside overlap");
  chk_incr_store: assert property (send && !i_addr_ctl.decrement && !i_addr_ctl.upd_to_buf
    |=> addr_hold_reg == add15($past(first_addr), fcs_pkg::INC_OPND, 1'b0))
    else $error("stored update address not incremented");
  chk_ptr_one: assert property (in_fetch && step_reg == fcs_pkg::STEP_I1D1 && force_one_reg
    |=> instr_pointer_reg == 15'h0001)
    else $error("trap transfer pointer not one");
  chk_trap_opcode: assert property (at_i4d1 && i_instr_ctl.ext_trap
    |=> o_opcode == fcs_pkg::TRAP_OPCODE && $stable(o_storage_word))
    else $error("trap did not force trap-store opcode");
  chk_route_odd: assert property (at_i4d1 && !i_instr_ctl.ext_trap && !i_instr_ctl.special
    && instr_pointer_reg[17] |=> o_storage_word == $past(i_even_bus))
    else $error("odd pointer did not route even bus");
  chk_tix_reload: assert property (at_i4d2 && i_instr_ctl.index_test_instr && !i_instr_ctl.ext_trap
    |=> lookahead_instr_buffer_reg == $past(op_word))
    else $error("index test word not reloaded");
  chk_exec_reset: assert property (cyc_reg == fcs_pkg::CYC_EXEC &&
    step_reg == fcs_pkg::STEP_E4D1 && !decide |=> !exec_trig_reg)
    else $error("execute trigger not reset at E4");
  chk_exec_block: assert property (i_chan_req |=> !o_exec_active)
    else $error("execute output not blocked");
  chk_fetch_block: assert property (i_chan_req |=> !o_fetch_active)
    else $error("fetch output not blocked");

  cov_fetch_chain: cover property (end_op_reg ##1 send);
  cov_trap_fetch: cover property (at_i4d1 && i_instr_ctl.ext_trap);
  cov_exec_stall: cover property (stall && cyc_reg == fcs_pkg::CYC_EXEC);

endmodule : fcs_fetch_cycle_sequencer

// [tb/fcs_core_mem.sv]
// core storage model: even and odd banks feeding the storage buses
// assumes latched addresses and one-cycle selects from the sequencer
module fcs_core_mem #(
  parameter int LAT_E = 2,
  parameter int LAT_O = 7
) (
  input wire logic i_ref_clk,
  input wire logic [3:17] i_even_addr,
  input wire logic [3:17] i_odd_addr,
  input wire logic i_even_sel,
  input wire logic i_odd_sel,
  output logic [0:35] o_even_bus,
  output logic [0:35] o_odd_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // banks and access timing
  // ----------------------------------------
  logic [0:35] mem [0:7];
  logic [3:17] ea_reg;
  logic [3:17] oa_reg;
  int ecnt = 99;
  int ocnt = 99;
  // cycles since select; one counter per bank, banks run independently
  always @(posedge i_ref_clk) begin
    ecnt <= i_even_sel ? 1 : ecnt + 1;
    ocnt <= i_odd_sel ? 1 : ocnt + 1;
    if (i_even_sel) ea_reg <= i_even_addr;
    if (i_odd_sel) oa_reg <= i_odd_addr;
  end
  // word stands from its latency to step 10; a moving pattern otherwise,
  // so a late or unselected sample sees the last word and its inverse in turn
  always @(negedge i_ref_clk) begin
    o_even_bus <= (ecnt >= LAT_E && ecnt <= 10) ? mem[ea_reg[15:17]] : ~o_even_bus;
    o_odd_bus <= (ocnt >= LAT_O && ocnt <= 10) ? mem[oa_reg[15:17]] : ~o_odd_bus;
  end
endmodule : fcs_core_mem

// [tb/tb.sv]
// bench for the fetch cycle sequencer against a core storage model
// assumes one 50 MHz clock; inputs change on the falling edge
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus, observation, instances
  // ----------------------------------------
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic fetch_req = 1'b0;
  logic chan_req = 1'b0;
  logic [3:17] idx = 15'h0002;
  fcs_pkg::fcs_addr_ctl_t ac = '0;
  fcs_pkg::fcs_instr_ctl_t ic = '0;
  logic [0:35] eb, ob, bw, sw;
  logic [3:17] ea, oa, ptr, hold, shc, sea, soa;
  logic es, os, ses, sos, bl, cm, pi, eo, fa, xa, la;
  logic [18:20] tg;
  logic [0:9] op;
  int err_count = 0;
  int n_tests = 0;
  fcs_fetch_cycle_sequencer u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_addr_ctl(ac), .i_instr_ctl(ic), .i_even_bus(eb), .i_odd_bus(ob),
    .i_index_reg(idx), .i_fetch_req(fetch_req), .i_chan_req(chan_req),
    .o_even_addr(ea), .o_odd_addr(oa), .o_even_sel(es), .o_odd_sel(os),
    .o_instr_pointer(ptr), .o_addr_hold(hold), .o_buffer(bw), .o_storage_word(sw),
    .o_tag_bits(tg), .o_opcode(op), .o_shift_count(shc), .o_buffer_loaded(bl),
    .o_cond_met(cm), .o_pre_indirect(pi), .o_end_op(eo), .o_fetch_active(fa),
    .o_exec_active(xa), .o_logic_active(la));
  fcs_core_mem u_mem (.i_ref_clk(i_ref_clk), .i_even_addr(ea), .i_odd_addr(oa),
    .i_even_sel(es), .i_odd_sel(os), .o_even_bus(eb), .o_odd_bus(ob));
  // free-running clock
  always #10 i_ref_clk = ~i_ref_clk;
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [0:35] mk(input logic s, input logic [8:0] o, input logic b12,
    input logic [2:0] t, input logic [14:0] a);
    mk = {s, 2'h0, o, b12, 5'h00, t, a};
  endfunction : mk
  task automatic base();
    ac = '0;
    ac.src = fcs_pkg::SRC_PTR;
    ac.overlap = 1'b1;
    ic = '0;
  endtask : base
  // wait for the selects, then stop at step 12 where all updates have landed
  task automatic fetch_cyc();
    int n;
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while ((es | os) !== 1'b1 && n < 100);
    chk("select seen", n < 100, 1'b1);
    sea = ea;
    soa = oa;
    ses = es;
    sos = os;
    repeat (12) @(negedge i_ref_clk);
  endtask : fetch_cyc
  task automatic t_reset();
    u_mem.mem[0] = mk(1'b0, 9'h0a5, 1'b0, 3'h5, 15'h0005);
    u_mem.mem[1] = mk(1'b1, 9'h1e0, 1'b0, 3'h0, 15'h0006);
    // bit 1 set so the short opcode form shows a nonzero field
    u_mem.mem[2] = mk(1'b0, 9'h0c3, 1'b0, 3'h2, 15'h0011) | 36'h400000000;
    u_mem.mem[3] = mk(1'b0, 9'h055, 1'b0, 3'h7, 15'h0022);
    u_mem.mem[4] = mk(1'b0, 9'h021, 1'b1, 3'h0, 15'h0007);
    u_mem.mem[7] = mk(1'b0, 9'h033, 1'b0, 3'h4, 15'h0009);
    repeat (5) @(negedge i_ref_clk);
    chk("pointer", ptr, 15'h0000);
    chk("triggers", {fa, xa, es, os}, 4'h0);
    i_sys_rst = 1'b0;
    // no fetch asked at the first decision, so a logic cycle follows
    repeat (12) @(negedge i_ref_clk);
    chk("logic cycle", {la, fa}, 2'h2);
    fetch_req = 1'b1;
    $display("test reset done");
  endtask : t_reset
  task automatic t_inc();
    base();
    ic.indexable = 1'b1;
    ic.index_sel = 1'b1;
    ic.one_cycle = 1'b1;
    ic.overlap_ok = 1'b1;
    fetch_cyc();
    chk("latches", {sea, soa, ses, sos}, {15'h0000, 15'h0001, 2'h3});
    chk("pointer", ptr, 15'h0001);
    chk("storage", sw, u_mem.mem[0]);
    chk("tags", tg, 3'h5);
    chk("opcode", op, {1'b0, 9'h0a5});
    chk("buffer", bw, u_mem.mem[1]);
    chk("modified", hold, 15'h0003);
    chk("flags", {bl, eo, fa}, 3'h7);
    $display("test increment done");
  endtask : t_inc
  task automatic t_prefix();
    base();
    ic.indexable = 1'b1;
    ic.exec_test = 1'b1;
    fetch_cyc();
    chk("latches", {sea, soa}, {15'h0002, 15'h0001});
    chk("pointer", ptr, 15'h0002);
    chk("opcode", op, {1'b1, 9'h1e0});
    chk("buffer", bw, u_mem.mem[2]);
    chk("zero index", hold, 15'h0006);
    chk("shift", shc, 15'h0006);
    chk("exec", xa, 1'b1);
    chan_req = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk("exec held", xa, 1'b0);
    chan_req = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk("exec free", xa, 1'b1);
    $display("test prefix done");
  endtask : t_prefix
  // trap drops both words; diagnostic keeps the second latch quiet
  task automatic t_trap();
    base();
    ac.decrement = 1'b1;
    ac.diag = 1'b1;
    ic.ext_trap = 1'b1;
    ic.one_cycle = 1'b1;
    fetch_cyc();
    chk("latch", {sea, ses, sos}, {15'h0002, 2'h2});
    chk("hold", hold, 15'h0001);
    chk("pointer", ptr, 15'h0002);
    chk("opcode", op, 10'h001);
    chk("storage", sw, u_mem.mem[1]);
    $display("test trap done");
  endtask : t_trap
  task automatic t_tix();
    base();
    ic.index_test_instr = 1'b1;
    ic.tix_pass = 1'b1;
    ic.overlap_ok = 1'b1;
    ic.one_cycle = 1'b1;
    ic.prefix_form = 1'b1;
    fetch_cyc();
    chk("pointer", ptr, 15'h0003);
    chk("short opcode", op, 10'h002);
    chk("reload", bw, u_mem.mem[2]);
    chk("no modify", hold, 15'h0003);
    chk("flags", {cm, bl}, 2'h3);
    $display("test index test done");
  endtask : t_tix
  task automatic t_force();
    base();
    ac.force_one = 1'b1;
    ic.indexable = 1'b1;
    ic.indirect_ok = 1'b1;
    fetch_cyc();
    chk("latches", {sea, soa}, {15'h0004, 15'h0003});
    chk("pointer", ptr, 15'h0001);
    chk("indirect", {pi, xa}, 2'h3);
    base();
    ac.upd_block = 1'b1;
    ac.src = fcs_pkg::SRC_HOLD;
    ic.one_cycle = 1'b1;
    ic.special = 1'b1;
    fetch_cyc();
    chk("hold latches", {sea, soa}, {15'h0008, 15'h0007});
    chk("special route", sw, u_mem.mem[7]);
    chk("blocked", ptr, 15'h0001);
    $display("test pointer paths done");
  endtask : t_force
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    t_reset();
    t_inc();
    t_prefix();
    t_trap();
    t_tix();
    t_force();
    end_of_test();
  end
  // watchdog: the run needs under 150 cycles, allow twenty times that
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    err_count++;
    end_of_test();
  end
endmodule : tb
